// File: core/icc_defs.svh
// register offsets, field positions, reset values and bus codes for the interrupt config block
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH

`define ICC_ADDR_W        8
`define ICC_CTRL_ADDR     8'h00
`define ICC_STAT_ADDR     8'h04
`define ICC_MASK_ADDR     8'h08

`define ICC_VECTOR_MODE_SELECT_BIT      12
`define ICC_TPC_HI        10
`define ICC_TPC_LO        8
`define ICC_EP_HI         4
`define ICC_EP_LO         0
`define ICC_NUM_EXT       5
`define ICC_PROX_BIT      5

`define ICC_CTRL_MASK     32'h0000_171f
`define ICC_CTRL_RST      32'h0000_0000
`define ICC_STAT_MASK     32'h0000_003f
`define ICC_STAT_RST      32'h0000_0000
`define ICC_MASK_RST      32'h0000_0000

`define ICC_TPC_OFF       3'h0
`define ICC_TPC_ONLY1     3'h1
`define ICC_PRIO_ONE      3'h1

`define ICC_RESP_OKAY     2'h0
`define ICC_RESP_SLVERR   2'h2

`endif

// File: core/icc_pkg.sv
// types shared by the interrupt config block
package icc_pkg;

  typedef enum logic [1:0] {
    ICC_WR_IDLE = 2'h1,
    ICC_WR_RESP = 2'h2
  } icc_wr_state_type;

  typedef enum logic [1:0] {
    ICC_RD_IDLE = 2'h1,
    ICC_RD_DATA = 2'h2
  } icc_rd_state_type;

endpackage

// File: core/icc_edge_det.sv
// pin synchroniser and selectable edge detector for one external interrupt
`timescale 1ns/1ns
`include "icc_defs.svh"

module icc_edge_det
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and edge choice
  input  wire logic pin,
  input  wire logic edge_sel,
  // request toward flag logic
  output logic      pulse
);

  logic sync1;
  logic sync2;
  logic prev;
  logic next_pulse;

  // compare only synchronised samples; sync1 feeds sync2 alone
  always_comb begin
    if (edge_sel) begin
      next_pulse = sync2 & ~prev;
    end else begin
      next_pulse = ~sync2 & prev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
      pulse <= next_pulse;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_edge_single;
    pulse |=> !pulse;
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("edge pulse longer than one cycle");

  property p_edge_sel;
    (edge_sel && sync2 && !prev) || (!edge_sel && !sync2 && prev) |=> pulse;
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("selected edge gave no pulse");

  property p_edge_latency;
    $rose(sync1) && edge_sel ##1 edge_sel |=> pulse;
  endproperty
  a_edge_latency: assert property (p_edge_latency) else $error("rising pulse not two cycles after sample");

endmodule

// File: core/icc_top.sv
// interrupt control configuration register, external edge detect and proximity start
// Operation
// - bit 12 one selects multi-vector dispatch
// - threshold 000 keeps proximity timer disabled
// - threshold 001: only priority 1 starts
// - threshold 010-111: priority <= threshold starts
// - ext input 0 edge by bit 0
// - ext input 1 edge by bit 1
// - ext input 2 edge by bit 2
// - ext input 3 edge by bit 3
// - ext input 4 edge by bit 4
// - unimplemented control bits read zero, ignore writes
`timescale 1ns/1ns
`include "icc_defs.svh"

module icc_top
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write address
  input  wire logic [`ICC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read address
  input  wire logic [`ICC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // external interrupt pins
  input  wire logic [`ICC_NUM_EXT-1:0]  ext_irq_pin,
  // interrupt taken by the controller
  input  wire logic                     irq_taken,
  input  wire logic [2:0]               irq_group_priority,
  // toward core and flag logic
  output logic                          vector_mode_select,
  output logic                          prox_timer_start,
  output logic [`ICC_NUM_EXT-1:0]       ext_irq_req,
  output logic                          irq
);

  icc_wr_state_type          wr_state;
  icc_wr_state_type          next_wr_state;
  icc_rd_state_type          rd_state;
  icc_rd_state_type          next_rd_state;
  logic                      aw_have;
  logic                      next_aw_have;
  logic                      w_have;
  logic                      next_w_have;
  logic [`ICC_ADDR_W-1:0]    wr_addr;
  logic [`ICC_ADDR_W-1:0]    next_wr_addr;
  logic [31:0]               wr_data;
  logic [31:0]               next_wr_data;
  logic [3:0]                wr_strb;
  logic [3:0]                next_wr_strb;
  logic [`ICC_ADDR_W-1:0]    rd_addr;
  logic [`ICC_ADDR_W-1:0]    next_rd_addr;
  logic                      next_awready;
  logic                      next_wready;
  logic                      next_arready;
  logic                      next_bvalid;
  logic [1:0]                next_bresp;
  logic                      next_rvalid;
  logic [1:0]                next_rresp;
  logic [31:0]               next_rdata;
  logic [31:0]               ctrl;
  logic [31:0]               next_ctrl;
  logic [31:0]               status;
  logic [31:0]               next_status;
  logic [31:0]               mask;
  logic [31:0]               next_mask;
  logic                      next_irq;
  logic                      next_prox;
  logic [31:0]               strb_bits;
  logic [31:0]               events;
  logic                      wr_fire;
  logic [2:0]                tpc;
  logic [`ICC_NUM_EXT-1:0]   edge_sel;
  logic [`ICC_NUM_EXT-1:0]   edge_pulse;

  assign tpc                = ctrl[`ICC_TPC_HI:`ICC_TPC_LO];
  assign edge_sel           = ctrl[`ICC_EP_HI:`ICC_EP_LO];
  assign vector_mode_select = ctrl[`ICC_VECTOR_MODE_SELECT_BIT];
  assign ext_irq_req        = edge_pulse;

  // one detector per pin; bit i of the edge field steers input i
  genvar gi;
  generate
    for (gi = 0; gi < `ICC_NUM_EXT; gi = gi + 1) begin : g_ext
      icc_edge_det u_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (ext_irq_pin[gi]),
        .edge_sel (edge_sel[gi]),
        .pulse    (edge_pulse[gi])
      );
    end
  endgenerate

  // proximity start decision, registered so the output is a clean pulse
  always_comb begin
    next_prox = 1'b0;
    if (irq_taken) begin
      case (tpc)
        `ICC_TPC_OFF: begin
          next_prox = 1'b0;
        end
        `ICC_TPC_ONLY1: begin
          next_prox = (irq_group_priority == `ICC_PRIO_ONE);
        end
        default: begin
          next_prox = (irq_group_priority <= tpc);
        end
      endcase
    end
  end

  // bus channels, register writes and status flags
  always_comb begin
    next_wr_state = wr_state;
    next_rd_state = rd_state;
    next_aw_have  = aw_have;
    next_w_have   = w_have;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_strb  = wr_strb;
    next_rd_addr  = rd_addr;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_rvalid   = s_axi_rvalid;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    next_ctrl     = ctrl;
    next_mask     = mask;
    strb_bits     = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    events        = {26'h0, next_prox, edge_pulse};
    next_status   = status;
    wr_fire       = 1'b0;
    case (wr_state)
      ICC_WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_have = 1'b1;
          next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_have  = 1'b1;
          next_wr_data = s_axi_wdata;
          next_wr_strb = s_axi_wstrb;
        end
        // both halves held: commit and answer on the next edge
        if (aw_have && w_have) begin
          wr_fire       = 1'b1;
          next_aw_have  = 1'b0;
          next_w_have   = 1'b0;
          next_bvalid   = 1'b1;
          next_bresp    = `ICC_RESP_OKAY;
          next_wr_state = ICC_WR_RESP;
          case (wr_addr)
            `ICC_CTRL_ADDR: begin
              next_ctrl = ((ctrl & ~strb_bits) | (wr_data & strb_bits))
                          & `ICC_CTRL_MASK;
            end
            `ICC_STAT_ADDR: begin
              next_status = status & ~(wr_data & strb_bits);
            end
            `ICC_MASK_ADDR: begin
              next_mask = ((mask & ~strb_bits) | (wr_data & strb_bits)) & `ICC_STAT_MASK;
            end
            default: begin
              next_bresp = `ICC_RESP_SLVERR;
            end
          endcase
        end
      end
      ICC_WR_RESP: begin
        if (s_axi_bready) begin
          next_bvalid   = 1'b0;
          next_wr_state = ICC_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = ICC_WR_IDLE;
      end
    endcase
    // a new event wins over a clear in the same cycle
    next_status = (next_status | events) & `ICC_STAT_MASK;
    case (rd_state)
      ICC_RD_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          next_rd_addr  = s_axi_araddr;
          next_rvalid   = 1'b1;
          next_rresp    = `ICC_RESP_OKAY;
          next_rd_state = ICC_RD_DATA;
          case (s_axi_araddr)
            `ICC_CTRL_ADDR: begin
              next_rdata = ctrl & `ICC_CTRL_MASK;
            end
            `ICC_STAT_ADDR: begin
              next_rdata = status;
            end
            `ICC_MASK_ADDR: begin
              next_rdata = mask;
            end
            default: begin
              next_rdata = 32'h0000_0000;
              next_rresp = `ICC_RESP_SLVERR;
            end
          endcase
        end
      end
      ICC_RD_DATA: begin
        if (s_axi_rready) begin
          next_rvalid   = 1'b0;
          next_rd_state = ICC_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = ICC_RD_IDLE;
      end
    endcase
    next_awready = (next_wr_state == ICC_WR_IDLE) && !next_aw_have && !wr_fire;
    next_wready  = (next_wr_state == ICC_WR_IDLE) && !next_w_have && !wr_fire;
    next_arready = (next_rd_state == ICC_RD_IDLE) && !(s_axi_arvalid && s_axi_arready);
    next_irq     = |(next_status & next_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state         <= ICC_WR_IDLE;
      rd_state         <= ICC_RD_IDLE;
      aw_have          <= 1'b0;
      w_have           <= 1'b0;
      wr_addr          <= 8'h00;
      wr_data          <= 32'h0000_0000;
      wr_strb          <= 4'h0;
      rd_addr          <= 8'h00;
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_arready    <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= `ICC_RESP_OKAY;
      s_axi_rvalid     <= 1'b0;
      s_axi_rresp      <= `ICC_RESP_OKAY;
      s_axi_rdata      <= 32'h0000_0000;
      ctrl             <= `ICC_CTRL_RST;
      status           <= `ICC_STAT_RST;
      mask             <= `ICC_MASK_RST;
      irq              <= 1'b0;
      prox_timer_start <= 1'b0;
    end else begin
      wr_state         <= next_wr_state;
      rd_state         <= next_rd_state;
      aw_have          <= next_aw_have;
      w_have           <= next_w_have;
      wr_addr          <= next_wr_addr;
      wr_data          <= next_wr_data;
      wr_strb          <= next_wr_strb;
      rd_addr          <= next_rd_addr;
      s_axi_awready    <= next_awready;
      s_axi_wready     <= next_wready;
      s_axi_arready    <= next_arready;
      s_axi_bvalid     <= next_bvalid;
      s_axi_bresp      <= next_bresp;
      s_axi_rvalid     <= next_rvalid;
      s_axi_rresp      <= next_rresp;
      s_axi_rdata      <= next_rdata;
      ctrl             <= next_ctrl;
      status           <= next_status;
      mask             <= next_mask;
      irq              <= next_irq;
      prox_timer_start <= next_prox;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctrl_write;
    aw_have && w_have && wr_state == ICC_WR_IDLE && wr_addr == `ICC_CTRL_ADDR;
  endsequence

  property p_vector_mode_select_write;
    (s_ctrl_write and wr_strb[1]) |=> vector_mode_select == $past(wr_data[`ICC_VECTOR_MODE_SELECT_BIT]);
  endproperty
  a_vector_mode_select_write: assert property (p_vector_mode_select_write) else $error("vector mode bit not written");

  property p_tpc_off;
    irq_taken && tpc == `ICC_TPC_OFF |=> !prox_timer_start;
  endproperty
  a_tpc_off: assert property (p_tpc_off) else $error("proximity start while disabled");

  property p_tpc_one;
    irq_taken && tpc == `ICC_TPC_ONLY1
      |=> prox_timer_start == ($past(irq_group_priority) == `ICC_PRIO_ONE);
  endproperty
  a_tpc_one: assert property (p_tpc_one) else $error("threshold one start wrong");

  property p_tpc_le;
    irq_taken && tpc > `ICC_TPC_ONLY1
      |=> prox_timer_start == ($past(irq_group_priority) <= $past(tpc));
  endproperty
  a_tpc_le: assert property (p_tpc_le) else $error("threshold compare start wrong");

  property p_no_start_idle;
    !irq_taken |=> !prox_timer_start;
  endproperty
  a_no_start_idle: assert property (p_no_start_idle) else $error("start without interrupt");

  property p_ctrl_reserved;
    s_axi_rvalid && rd_addr == `ICC_CTRL_ADDR |-> (s_axi_rdata & ~`ICC_CTRL_MASK) == 32'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits read nonzero");

  property p_ctrl_reset;
    $rose(aresetn) |-> ctrl == `ICC_CTRL_RST && !vector_mode_select;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not clear after reset");

  property p_ext_flag;
    edge_pulse[0] |=> status[0];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("edge request did not set flag");

  sequence s_wr_commit;
    aw_have && w_have && wr_state == ICC_WR_IDLE;
  endsequence

  property p_bresp_follows;
    s_wr_commit |=> s_axi_bvalid ##1 (s_axi_bvalid || $past(s_axi_bready));
  endproperty
  a_bresp_follows: assert property (p_bresp_follows) else $error("write response missing");

  property p_irq_level;
    |(status & mask) |-> irq || $past(~|(status & mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised for unmasked flag");

endmodule

// File: verification/icc_core_model.sv
// behavioural model of the processor core side and the external interrupt pins
`timescale 1ns/1ns
`include "icc_defs.svh"

module icc_core_model (
  // clock
  input  wire logic                    aclk,
  // pins and taken interrupt
  output logic [`ICC_NUM_EXT-1:0]      ext_irq_pin,
  output logic                         irq_taken,
  output logic [2:0]                   irq_group_priority
);
  initial begin
    ext_irq_pin = 5'h00;
    irq_taken = 1'b0;
    irq_group_priority = 3'h0;
  end

  // priority is garbage outside the taken cycle, so stale use shows up
  task take(input logic [2:0] p);
    @(posedge aclk);
    irq_taken <= 1'b1;
    irq_group_priority <= p;
    @(posedge aclk);
    irq_taken <= 1'b0;
    irq_group_priority <= ~p;
  endtask

  task set_pin(input int i, input logic v);
    @(posedge aclk);
    ext_irq_pin[i] <= v;
  endtask
endmodule

// File: verification/interrupt_control_config_tb_top.sv
// self-checking testbench for the interrupt control configuration block
`timescale 1ns/1ns
`include "icc_defs.svh"

module interrupt_control_config_tb_top
  import icc_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [4:0]  pins;
  logic        taken;
  logic [2:0]  prio;
  logic        vms;
  logic        pts;
  logic [4:0]  req;
  logic        irq;
  logic [31:0] d;
  logic [1:0]  r;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #5 aclk = ~aclk;

  icc_core_model i_core (.aclk(aclk), .ext_irq_pin(pins), .irq_taken(taken),
    .irq_group_priority(prio));

  icc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_irq_pin(pins), .irq_taken(taken),
    .irq_group_priority(prio), .vector_mode_select(vms),
    .prox_timer_start(pts), .ext_irq_req(req), .irq(irq));

  task end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // budget well above the full sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // counts start pulses and request pulses of pin i over a settled window
  task watch(input int i, output int np, output int ne, output int nr);
    np = 0;
    ne = 0;
    nr = 0;
    repeat (6) begin
      @(negedge aclk);
      np += (pts === 1'b1);
      ne += (req === (5'h01 << i));
      nr += (req !== 5'h00);
    end
  endtask

  task t_reset();
    rd(`ICC_CTRL_ADDR, d, r);
    chk("ctrl reset", d, `ICC_CTRL_RST);
    chk("vector mode reset", {31'h0, vms}, 32'h0);
  endtask

  task t_ctrl_bits();
    wr(`ICC_CTRL_ADDR, 32'hffff_ffff, r);
    chk("write resp", {30'h0, r}, {30'h0, `ICC_RESP_OKAY});
    rd(`ICC_CTRL_ADDR, d, r);
    chk("ctrl all ones", d, 32'h0000_171f);
    chk("multi vector", {31'h0, vms}, 32'h1);
    wr(`ICC_CTRL_ADDR, 32'h0000_e8e0, r);
    rd(`ICC_CTRL_ADDR, d, r);
    chk("ctrl holes", d, 32'h0);
    chk("single vector", {31'h0, vms}, 32'h0);
  endtask

  task t_prox();
    int np, ne, nr, e;
    for (int t = 0; t < 8; t++) begin
      wr(`ICC_CTRL_ADDR, 32'(t) << 8, r);
      for (int p = 0; p < 8; p++) begin
        i_core.take(3'(p));
        watch(0, np, ne, nr);
        e = (t == 0) ? 0 : (t == 1) ? int'(p == 1) : int'(p <= t);
        chk("prox start", 32'(np), 32'(e));
      end
    end
  endtask

  task t_edges();
    int np, ne, nr;
    for (int i = 0; i < 5; i++) begin
      for (int s = 0; s < 2; s++) begin
        wr(`ICC_CTRL_ADDR, 32'(s) << i, r);
        i_core.set_pin(i, 1'b1);
        watch(i, np, ne, nr);
        chk("rise pulse", 32'(ne), 32'(s));
        chk("rise any", 32'(nr), 32'(s));
        i_core.set_pin(i, 1'b0);
        watch(i, np, ne, nr);
        chk("fall pulse", 32'(ne), 32'(1 - s));
        chk("fall any", 32'(nr), 32'(1 - s));
      end
    end
  endtask

  // irq must track status and mask, with write-one-clear
  task t_irq();
    int np, ne, nr;
    wr(`ICC_STAT_ADDR, 32'h0000_003f, r);
    wr(`ICC_MASK_ADDR, 32'h0000_0001, r);
    wr(`ICC_CTRL_ADDR, 32'h0000_0001, r);
    i_core.set_pin(0, 1'b1);
    watch(0, np, ne, nr);
    chk("irq set", {31'h0, irq}, 32'h1);
    rd(`ICC_STAT_ADDR, d, r);
    chk("status", d, 32'h1);
    wr(`ICC_MASK_ADDR, 32'h0, r);
    repeat (2) @(negedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`ICC_MASK_ADDR, 32'h1, r);
    repeat (2) @(negedge aclk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(`ICC_STAT_ADDR, 32'h1, r);
    repeat (2) @(negedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd(`ICC_STAT_ADDR, d, r);
    chk("status cleared", d, 32'h0);
    i_core.set_pin(0, 1'b0);
  endtask

  task t_unmapped();
    wr(8'h0c, 32'hffff_ffff, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, `ICC_RESP_SLVERR});
    rd(8'h0c, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, `ICC_RESP_SLVERR});
    chk("unmapped rdata", d, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ctrl_bits();
    t_prox();
    t_edges();
    t_irq();
    t_unmapped();
    end_sim();
  end
endmodule
